// ===== rtl/difd_decoder.sv
// Terminal function decoder for a frequency inverter
`timescale 1ns/1ps
`include "difd_defines.svh"
module difd_decoder #(
   parameter int NUM_TERM = 6
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NUM_TERM-1:0] term_pin,
   input wire logic [NUM_TERM*`DIFD_CODE_W-1:0] term_code,
   input wire logic [NUM_TERM*2-1:0] term_polarity,
   input wire logic [1:0] pid_enable_config,
   input wire logic [1:0] pot_storage_config,
   input wire logic [1:0] reference_source,
   input wire logic frequency_offset_sign,
   output logic motor_run,
   output logic motor_reverse,
   output logic pid_suspend,
   output logic integral_term_clear,
   output logic pot_speed_up,
   output logic pot_slow_down,
   output logic pot_value_clear,
   output logic keypad_priority,
   output logic offset_add,
   output logic offset_negative,
   output logic terminal_priority,
   output logic fast_response,
   output logic extended_second_set,
   output logic current_input_select,
   output logic voltage_input_ignore
);
   import difd_pkg::*;

   typedef struct packed {
      difd_run_t run;
      logic run_out;
      logic rev;
      logic start_prev;
      logic pid_susp;
      logic int_clr;
      logic up;
      logic dn;
      logic pclr;
      logic kp;
      logic add;
      logic neg;
      logic tp;
      logic fast;
      logic ext;
      logic cur;
   } difd_state_t;

   difd_state_t st_ff;
   difd_state_t nxt_st;
   logic [NUM_TERM-1:0] filt;
   logic [NUM_TERM-1:0] act;

   genvar g;
   generate
      for (g = 0; g < NUM_TERM; g++) begin : g_term
         difd_filter #(
            .LEN(`DIFD_FILT_LEN)
         ) u_filt (
            .clk(clk),
            .rst_n(rst_n),
            .pin(term_pin[g]),
            .level(filt[g])
         );
         // Normally closed contacts activate on a low level
         assign act[g] = (term_polarity[g*2 +: 2] == `DIFD_POL_NC)
            ? ~filt[g] : filt[g];
      end
   endgenerate

   // Active when some terminal holds the code and is asserted
   function automatic logic fn_on(input logic [`DIFD_CODE_W-1:0] code,
                                  input logic [NUM_TERM-1:0] a,
                                  input logic [NUM_TERM*`DIFD_CODE_W-1:0] codes);
      logic r;
      r = 1'b0;
      for (int i = 0; i < NUM_TERM; i++) begin
         // Unused code never matches any function
         if (codes[i*`DIFD_CODE_W +: `DIFD_CODE_W] == code
             && code != `DIFD_FN_UNUSED) begin
            r = r | a[i];
         end
      end
      return r;
   endfunction

   logic start_on;
   logic stop_on;
   logic dir_on;
   logic keypad_src;

   always_comb begin
      start_on = fn_on(`DIFD_FN_3W_START, act, term_code);
      stop_on = fn_on(`DIFD_FN_3W_STOP, act, term_code);
      dir_on = fn_on(`DIFD_FN_3W_DIR, act, term_code);
      keypad_src = (reference_source == `DIFD_SRC_KEYPAD);
      nxt_st = st_ff;
      nxt_st.start_prev = start_on;
      case (st_ff.run)
         DIFD_IDLE: begin
            // Start pulse latches the run with direction set at start, then following the direction terminal while running
            if (start_on && !st_ff.start_prev && stop_on) begin
               nxt_st.run = DIFD_RUN;
               nxt_st.rev = dir_on;
            end
         end
         DIFD_RUN: begin
            nxt_st.rev = dir_on;
            if (!stop_on) begin
               nxt_st.run = DIFD_IDLE;
            end
         end
         default: begin
            nxt_st.run = DIFD_IDLE;
         end
      endcase
      // Run output held in its own flop so the port comes straight from a register
      nxt_st.run_out = (nxt_st.run == DIFD_RUN);
      nxt_st.pid_susp = fn_on(`DIFD_FN_PID_SUSPEND, act, term_code)
         && (pid_enable_config == `DIFD_PID_ON);
      nxt_st.int_clr = fn_on(`DIFD_FN_INT_CLEAR, act, term_code);
      nxt_st.up = fn_on(`DIFD_FN_POT_UP, act, term_code) && keypad_src;
      nxt_st.dn = fn_on(`DIFD_FN_POT_DOWN, act, term_code) && keypad_src;
      nxt_st.pclr = fn_on(`DIFD_FN_POT_CLEAR, act, term_code)
         && (pot_storage_config == `DIFD_POT_STORE_CLR_OK);
      nxt_st.kp = fn_on(`DIFD_FN_KEYPAD_PRIO, act, term_code);
      nxt_st.add = fn_on(`DIFD_FN_OFFSET_ADD, act, term_code);
      nxt_st.neg = nxt_st.add && frequency_offset_sign;
      nxt_st.tp = fn_on(`DIFD_FN_TERM_PRIO, act, term_code);
      nxt_st.fast = fn_on(`DIFD_FN_FAST_RESP, act, term_code);
      nxt_st.ext = fn_on(`DIFD_FN_EXT_SET, act, term_code);
      nxt_st.cur = fn_on(`DIFD_FN_CURRENT_SEL, act, term_code);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign motor_run = st_ff.run_out;
   assign motor_reverse = st_ff.rev;
   assign pid_suspend = st_ff.pid_susp;
   assign integral_term_clear = st_ff.int_clr;
   assign pot_speed_up = st_ff.up;
   assign pot_slow_down = st_ff.dn;
   assign pot_value_clear = st_ff.pclr;
   assign keypad_priority = st_ff.kp;
   assign offset_add = st_ff.add;
   assign offset_negative = st_ff.neg;
   assign terminal_priority = st_ff.tp;
   assign fast_response = st_ff.fast;
   assign extended_second_set = st_ff.ext;
   assign current_input_select = st_ff.cur;
   assign voltage_input_ignore = st_ff.cur;
endmodule // difd_decoder

// ===== rtl/difd_defines.svh
// Constants for the drive input function decoder
`ifndef DIFD_DEFINES_SVH
`define DIFD_DEFINES_SVH
`define DIFD_CODE_W 8
`define DIFD_FN_CURRENT_SEL 8'h10
`define DIFD_FN_3W_START 8'h14
`define DIFD_FN_3W_STOP 8'h15
`define DIFD_FN_3W_DIR 8'h16
`define DIFD_FN_PID_SUSPEND 8'h17
`define DIFD_FN_INT_CLEAR 8'h18
`define DIFD_FN_POT_UP 8'h1B
`define DIFD_FN_POT_DOWN 8'h1C
`define DIFD_FN_POT_CLEAR 8'h1D
`define DIFD_FN_KEYPAD_PRIO 8'h1F
`define DIFD_FN_OFFSET_ADD 8'h32
`define DIFD_FN_TERM_PRIO 8'h33
`define DIFD_FN_FAST_RESP 8'h34
`define DIFD_FN_EXT_SET 8'h35
`define DIFD_FN_UNUSED 8'hFF
`define DIFD_POL_NO 2'h0
`define DIFD_POL_NC 2'h1
`define DIFD_PID_ON 2'h1
`define DIFD_POT_STORE_CLR_OK 2'h0
`define DIFD_SRC_KEYPAD 2'h0
`define DIFD_FILT_LEN 4
`endif

// ===== rtl/difd_filter.sv
// Input synchroniser and noise filter for one terminal
`timescale 1ns/1ps
`include "difd_defines.svh"
module difd_filter #(
   parameter int LEN = `DIFD_FILT_LEN
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic [LEN-1:0] hist;
      logic lvl;
   } difd_filt_t;
   difd_filt_t st_ff;
   difd_filt_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = pin;
      nxt_st.s2 = st_ff.s1;
      nxt_st.hist = {st_ff.hist[LEN-2:0], st_ff.s2};
      // Change only when every sample in the window agrees
      if (&st_ff.hist) begin
         nxt_st.lvl = 1'b1;
      end else if (~|st_ff.hist) begin
         nxt_st.lvl = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level = st_ff.lvl;
endmodule // difd_filter

// ===== rtl/difd_pkg.sv
// Types for the drive input function decoder
package difd_pkg;
   typedef enum logic [1:0] {
      DIFD_IDLE,
      DIFD_RUN
   } difd_run_t;
endpackage

// ===== test/difd_decoder_assertions.sv
// Checker for the drive input function decoder
`timescale 1ns/1ps
module difd_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [47:0] term_code,
   input wire logic [1:0] pid_enable_config,
   input wire logic [1:0] pot_storage_config,
   input wire logic [1:0] reference_source,
   input wire logic motor_run,
   input wire logic pid_suspend,
   input wire logic pot_speed_up,
   input wire logic pot_slow_down,
   input wire logic pot_value_clear,
   input wire logic offset_add,
   input wire logic offset_negative,
   input wire logic current_input_select,
   input wire logic voltage_input_ignore
);
   logic [1:0] cnt_ff;
   always_ff @(posedge clk) begin
      if (!rst_n || term_code != {6{8'hFF}}) cnt_ff <= 2'h0;
      else if (cnt_ff != 2'h3) cnt_ff <= cnt_ff + 2'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rst;
      disable iff (1'b0) !rst_n |=> !motor_run && !pid_suspend && !offset_add;
   endproperty
   a_rst: assert property (p_rst) else $error("output active after reset");
   property p_unused;
      cnt_ff == 2'h3 |-> !(pid_suspend | pot_speed_up | pot_value_clear | offset_add
         | current_input_select);
   endproperty
   a_unused: assert property (p_unused) else $error("unused terminal drove a function");
   property p_pid; pid_suspend |-> $past(pid_enable_config) == 2'h1; endproperty
   a_pid: assert property (p_pid) else $error("suspend without enable");
   property p_up; pot_speed_up |-> $past(reference_source) == 2'h0; endproperty
   a_up: assert property (p_up) else $error("speed up off keypad source");
   property p_dn; pot_slow_down |-> $past(reference_source) == 2'h0; endproperty
   a_dn: assert property (p_dn) else $error("slow down off keypad source");
   property p_clr; pot_value_clear |-> $past(pot_storage_config) == 2'h0; endproperty
   a_clr: assert property (p_clr) else $error("pot clear with wrong storage");
   property p_neg; offset_negative |-> offset_add; endproperty
   a_neg: assert property (p_neg) else $error("negative without offset add");
   property p_volt; voltage_input_ignore == current_input_select; endproperty
   a_volt: assert property (p_volt) else $error("voltage ignore mismatch");
endmodule // difd_chk
bind difd_decoder difd_chk difd_chk_i (.clk(clk), .rst_n(rst_n), .term_code(term_code),
   .pid_enable_config(pid_enable_config), .pot_storage_config(pot_storage_config),
   .reference_source(reference_source), .motor_run(motor_run), .pid_suspend(pid_suspend),
   .pot_speed_up(pot_speed_up), .pot_slow_down(pot_slow_down), .offset_add(offset_add),
   .pot_value_clear(pot_value_clear), .offset_negative(offset_negative),
   .current_input_select(current_input_select), .voltage_input_ignore(voltage_input_ignore));

// ===== test/difd_switch_model.sv
// Terminal contacts with commanded bounce
`timescale 1ns/1ps
module difd_switch_model (
   input wire logic [5:0] level_req,
   input wire logic [5:0] bounce,
   output logic [5:0] term_pin
);
   assign term_pin = level_req ^ bounce;
endmodule // difd_switch_model

// ===== test/tb_drive_input_function_decoder.sv
// Testbench for the drive input function decoder
`timescale 1ns/1ps
module tb_drive_input_function_decoder;
   logic clk, rst_n, sgn;
   logic [5:0] lvl, gl, pin;
   logic [47:0] code;
   logic [11:0] pol;
   logic [1:0] pid_cfg, sto_cfg, src;
   logic [14:0] o, e;
   int fails = 0, cmp_count = 0, cyc = 0;
   logic [7:0] fc [11] = '{8'h17, 8'h18, 8'h1B, 8'h1C, 8'h1D, 8'h1F, 8'h32, 8'h33, 8'h34, 8'h35, 8'h10};
   logic [14:0] fm [11] = '{15'h1000, 15'h0800, 15'h0400, 15'h0200, 15'h0100, 15'h0080,
      15'h0060, 15'h0010, 15'h0008, 15'h0004, 15'h0003};
   difd_switch_model difd_switch_model_i (.level_req(lvl), .bounce(gl), .term_pin(pin));
   difd_decoder #(.NUM_TERM(6)) difd_decoder_i (.clk(clk), .rst_n(rst_n), .term_pin(pin),
      .term_code(code), .term_polarity(pol), .pid_enable_config(pid_cfg),
      .pot_storage_config(sto_cfg), .reference_source(src), .frequency_offset_sign(sgn),
      .motor_run(o[14]), .motor_reverse(o[13]), .pid_suspend(o[12]), .integral_term_clear(o[11]),
      .pot_speed_up(o[10]), .pot_slow_down(o[9]), .pot_value_clear(o[8]), .keypad_priority(o[7]),
      .offset_add(o[6]), .offset_negative(o[5]), .terminal_priority(o[4]), .fast_response(o[3]),
      .extended_second_set(o[2]), .current_input_select(o[1]), .voltage_input_ignore(o[0]));
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   task automatic complete_run();
      $display("fails %0d cmp_count %0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [14:0] x);
      cmp_count++;
      if (o !== x) begin
         fails++;
         $display("unexpected at %0t: outputs %h expected %h", $time, o, x);
      end
   endtask
   task automatic setp(input int t, input logic [7:0] c, input logic [1:0] p);
      code[8*t +: 8] = c;
      pol[2*t +: 2] = p;
   endtask
   task automatic drive(input logic [5:0] v);
      lvl = v;
      repeat (12) @(negedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         complete_run();
      end
   end
   initial begin
      rst_n = 1'b0;
      lvl = 6'h00;
      gl = 6'h00;
      code = {6{8'hFF}};
      pol = 12'h000;
      {pid_cfg, sto_cfg, src, sgn} = 7'h21;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      drive(6'h3F);
      chk(15'h0000);
      // Second pass turns PID, storage and keypad source off and the sign positive
      for (int k = 0; k < 22; k++) begin
         setp(0, fc[k % 11], 2'h0);
         if (k == 11) begin
            {pid_cfg, sto_cfg, src, sgn} = 7'h0A;
         end
         e = fm[k % 11];
         if (k > 10 && fc[k % 11] inside {8'h17, 8'h1B, 8'h1C, 8'h1D}) begin
            e = 15'h0000;
         end
         if (k > 10 && fc[k % 11] == 8'h32) begin
            e = 15'h0040;
         end
         drive(6'h01);
         chk(e);
         drive(6'h00);
         chk(15'h0000);
      end
      {pid_cfg, sto_cfg, src, sgn} = 7'h21;
      setp(0, 8'h1F, 2'h1);
      drive(6'h00);
      chk(15'h0080);
      drive(6'h01);
      chk(15'h0000);
      // A three-sample pulse on an idle contact must never reach the outputs
      setp(0, 8'h34, 2'h0);
      drive(6'h00);
      gl = 6'h01;
      repeat (3) @(negedge clk);
      gl = 6'h00;
      repeat (8) begin
         @(negedge clk);
         chk(15'h0000);
      end
      // Three-wire control: stop on terminal 0, start on terminal 1, direction on terminal 2
      setp(0, 8'h15, 2'h0);
      setp(1, 8'h14, 2'h0);
      setp(2, 8'h16, 2'h0);
      drive(6'h02);
      chk(15'h0000);
      drive(6'h01);
      chk(15'h0000);
      drive(6'h07);
      chk(15'h6000);
      drive(6'h05);
      chk(15'h6000);
      drive(6'h01);
      chk(15'h4000);
      drive(6'h00);
      chk(15'h0000);
      complete_run();
   end
endmodule // tb_drive_input_function_decoder
